// *** hdl/qbs_regs.svh ***
// constants of the burst-of-two sram port
`ifndef QBS_REGS_SVH
`define QBS_REGS_SVH
`define QBS_WIDE 0
`define QBS_WORD_W ((`QBS_WIDE != 0) ? 36 : 18)
`define QBS_ADDR_W ((`QBS_WIDE != 0) ? 18 : 19)
`define QBS_LANES ((`QBS_WIDE != 0) ? 4 : 2)
`define QBS_LANE_W 9
`define QBS_STRAP_CYC 8
`define QBS_STRAP_CNT_W 4
`endif

// *** hdl/qbs_pkg.sv ***
// types and lane merge function of the burst-of-two sram port
`include "qbs_regs.svh"
package qbs_pkg;
  typedef logic [`QBS_WORD_W-1:0] qbs_word_t;
  typedef logic [`QBS_LANES-1:0] qbs_lane_t;
  typedef logic [`QBS_ADDR_W-1:0] qbs_addr_t;
  typedef struct packed {
    qbs_word_t data;
    qbs_lane_t lane_n;
  } qbs_beat_t;
  typedef struct packed {
    qbs_word_t hi;
    qbs_word_t lo;
  } qbs_burst_t;

  // keep old lane where its select is high
  function automatic qbs_word_t qbs_lane_merge(input qbs_word_t old_w, input qbs_beat_t beat);
    qbs_word_t res;
    res = old_w;
    for (int i = 0; i < `QBS_LANES; i++) begin
      if (!beat.lane_n[i]) begin
        res[i*`QBS_LANE_W +: `QBS_LANE_W] = beat.data[i*`QBS_LANE_W +: `QBS_LANE_W];
      end
    end
    return res;
  endfunction : qbs_lane_merge
endpackage : qbs_pkg

// *** hdl/qbs_rd_launch.sv ***
// read data output launcher on the output clock pair, or on the main strobes in single-clock mode
`timescale 1ns/1ps
module qbs_rd_launch
  import qbs_pkg::*;
(
  input wire logic launch_p_clk,
  input wire logic launch_n_clk,
  input wire logic link_rst,
  input wire qbs_burst_t burst,
  input wire logic burst_valid,
  output qbs_word_t rd_data,
  output logic rd_data_oe
);
  logic rst_s1_q;
  logic rst_q;
  logic ptog_q;
  logic ntog_q;
  logic oe_p_q;
  logic oe_n_q;
  qbs_word_t lo_q;
  qbs_word_t hi_hold_q;
  qbs_word_t hi_q;
  wire show_lo = ptog_q != ntog_q;

  always_ff @(posedge launch_p_clk) begin
    rst_s1_q <= link_rst;
    rst_q <= rst_s1_q;
  end

  // word 0 and output enable change on the positive output edge
  always_ff @(posedge launch_p_clk) begin
    if (rst_q) begin
      ptog_q <= 1'b0;
      oe_p_q <= 1'b0;
      lo_q <= '0;
      hi_hold_q <= '0;
    end else begin
      ptog_q <= ~ptog_q;
      oe_p_q <= burst_valid;
      lo_q <= burst.lo;
      hi_hold_q <= burst.hi;
    end
  end

  // word 1 follows on the negative output edge
  always_ff @(posedge launch_n_clk) begin
    if (rst_q) begin
      ntog_q <= 1'b0;
      oe_n_q <= 1'b0;
      hi_q <= '0;
    end else begin
      ntog_q <= ptog_q;
      oe_n_q <= oe_p_q;
      hi_q <= hi_hold_q;
    end
  end

  assign rd_data = show_lo ? lo_q : hi_q;
  assign rd_data_oe = show_lo ? oe_p_q : oe_n_q;
endmodule : qbs_rd_launch

// *** hdl/qbs_sram_port.sv ***
// burst-of-two double data rate sram port, device side
`timescale 1ns/1ps
`include "qbs_regs.svh"
module qbs_sram_port
  import qbs_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic main_strobe_p,
  input wire logic main_strobe_n,
  input wire logic read_timing_p,
  input wire logic read_timing_n,
  input wire logic write_port_sel_n,
  input wire logic read_port_sel_n,
  input wire qbs_lane_t byte_lane_sel_n,
  input wire qbs_addr_t addr,
  input wire qbs_word_t wr_data,
  output qbs_word_t rd_data,
  output logic rd_data_oe,
  output logic single_clock_mode
);
  // core domain: strap sampling of the output clock pins
  logic rtp_s1_q;
  logic rtp_s2_q;
  logic rtn_s1_q;
  logic rtn_s2_q;
  logic [`QBS_STRAP_CNT_W-1:0] strap_cnt_q;
  logic [`QBS_STRAP_CNT_W-1:0] strap_cnt_d;
  logic strap_done_q;
  logic single_q;
  wire both_high = rtp_s2_q & rtn_s2_q;
  wire strap_full = strap_cnt_q == `QBS_STRAP_CNT_W'(`QBS_STRAP_CYC);

  always_ff @(posedge core_clk) begin
    rtp_s1_q <= read_timing_p;
    rtp_s2_q <= rtp_s1_q;
    rtn_s1_q <= read_timing_n;
    rtn_s2_q <= rtn_s1_q;
  end

  assign strap_cnt_d = both_high ? strap_cnt_q + `QBS_STRAP_CNT_W'(1) : '0;

  // mode is decided once after reset release, then frozen
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_cnt_q <= '0;
      strap_done_q <= 1'b0;
      single_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_d;
      if (strap_full) begin
        single_q <= 1'b1;
        strap_done_q <= 1'b1;
      end else if (!both_high) begin
        single_q <= 1'b0;
        strap_done_q <= 1'b1;
      end
    end
  end

  assign single_clock_mode = single_q;

  // link domain on main_strobe_p: reset and mode synchronisers
  logic krst_s1_q;
  logic krst_q;
  logic kmode_s1_q;
  logic kmode_q;

  always_ff @(posedge main_strobe_p) begin
    krst_s1_q <= srst;
    krst_q <= krst_s1_q;
    kmode_s1_q <= single_q;
    kmode_q <= kmode_s1_q;
  end

  // storage: each location holds a lower and upper word
  qbs_burst_t mem [0:(1 << `QBS_ADDR_W)-1];

  // write side, first half on main_strobe_p
  logic wr_go_q;
  qbs_beat_t wbeat0_q;

  always_ff @(posedge main_strobe_p) begin
    if (krst_q) begin
      wr_go_q <= 1'b0;
    end else begin
      wr_go_q <= ~write_port_sel_n;
    end
  end

  always_ff @(posedge main_strobe_p) begin
    if (!write_port_sel_n) begin
      wbeat0_q <= '{data: wr_data, lane_n: byte_lane_sel_n};
    end
  end

  // write side, second half on main_strobe_n, then array update
  wire qbs_beat_t wbeat1 = '{data: wr_data, lane_n: byte_lane_sel_n};
  wire qbs_burst_t wold = mem[addr];
  wire qbs_burst_t wnew = '{hi: qbs_lane_merge(wold.hi, wbeat1), lo: qbs_lane_merge(wold.lo, wbeat0_q)};

  always_ff @(posedge main_strobe_n) begin
    if (wr_go_q) begin
      mem[addr] <= wnew;
    end
  end

  // read side on main_strobe_p
  logic rd_go_q;
  qbs_addr_t rd_addr_q;

  always_ff @(posedge main_strobe_p) begin
    if (krst_q) begin
      rd_go_q <= 1'b0;
    end else begin
      rd_go_q <= ~read_port_sel_n;
    end
  end

  always_ff @(posedge main_strobe_p) begin
    if (!read_port_sel_n) begin
      rd_addr_q <= addr;
    end
  end

  wire qbs_burst_t rd_burst = mem[rd_addr_q];

  // second read stage: output edges after the next main_strobe_p rise
  logic rd_go2_q;
  qbs_burst_t rd_burst2_q;

  always_ff @(posedge main_strobe_p) begin
    if (krst_q) begin
      rd_go2_q <= 1'b0;
    end else begin
      rd_go2_q <= rd_go_q;
    end
  end

  always_ff @(posedge main_strobe_p) begin
    rd_burst2_q <= rd_burst;
  end

  // single-clock launch edge is itself the next main_strobe_p rise
  wire qbs_burst_t launch_burst = kmode_q ? rd_burst : rd_burst2_q;
  wire launch_valid = kmode_q ? rd_go_q : rd_go2_q;

  // output clock pair, or the main strobes in single-clock mode
  wire launch_p = kmode_q ? main_strobe_p : read_timing_p;
  wire launch_n = kmode_q ? main_strobe_n : read_timing_n;

  qbs_rd_launch u_launch (
    .launch_p_clk(launch_p),
    .launch_n_clk(launch_n),
    .link_rst(krst_q),
    .burst(launch_burst),
    .burst_valid(launch_valid),
    .rd_data(rd_data),
    .rd_data_oe(rd_data_oe)
  );
endmodule : qbs_sram_port

// *** sim/qbs_sram_port_chk.sv ***
// read port assertions
`timescale 1ns/1ps
module qbs_sram_port_chk (
  input wire logic srst,
  input wire logic read_timing_p,
  input wire logic write_port_sel_n,
  input wire logic read_port_sel_n,
  input wire logic rd_data_oe
);
  default clocking cb @(posedge read_timing_p); endclocking
  default disable iff (srst);
  sequence s_rd1;
    read_port_sel_n ##1 !read_port_sel_n ##1 read_port_sel_n;
  endsequence
  sequence s_pulse;
    $rose(rd_data_oe) ##1 $fell(rd_data_oe);
  endsequence
  AST_ON: assert property (!read_port_sel_n |-> ##2 rd_data_oe) else $error("read not driven");
  AST_OFF: assert property (read_port_sel_n |-> ##2 !rd_data_oe) else $error("idle driven");
  AST_BURST: assert property (s_rd1 |-> ##1 s_pulse) else $error("bad burst");
  AST_B2B: assert property (!read_port_sel_n [*2] |-> ##1 rd_data_oe [*2]) else $error("burst gap");
  AST_WR: assert property (read_port_sel_n && !write_port_sel_n |-> ##2 !rd_data_oe) else $error("write drove");
  AST_RISE: assert property ($rose(rd_data_oe) |-> !$past(read_port_sel_n, 2)) else $error("early drive");
  AST_FALL: assert property ($fell(rd_data_oe) |-> $past(read_port_sel_n, 2)) else $error("early float");
  AST_IDLE: assert property (read_port_sel_n [*2] |-> ##1 !rd_data_oe [*2]) else $error("idle drive");
endmodule : qbs_sram_port_chk
bind qbs_sram_port qbs_sram_port_chk CHK (.*);

// *** sim/qbs_ctl_model.sv ***
// controller clock model
`timescale 1ns/1ps
module qbs_ctl_model (
  input wire logic strap_hi,
  output logic main_strobe_p = 1'h0,
  output logic main_strobe_n,
  output logic read_timing_p,
  output logic read_timing_n
);
  logic rt_clk;
  initial #13 forever #40 main_strobe_p = ~main_strobe_p;
  assign main_strobe_n = ~main_strobe_p;
  // output clocks lag the main strobe; both held high strap single-clock mode
  assign #10 rt_clk = main_strobe_p;
  assign read_timing_p = strap_hi | rt_clk;
  assign read_timing_n = strap_hi | ~rt_clk;
endmodule : qbs_ctl_model

// *** sim/tb.sv ***
// bench: controller traffic, read scoreboard
`timescale 1ns/1ps
module tb;
  import qbs_pkg::*;
  logic core_clk = 1'h0, srst = 1'h1, write_port_sel_n = 1'h1, read_port_sel_n = 1'h1;
  logic main_strobe_p, main_strobe_n, read_timing_p, read_timing_n, rd_data_oe, single_clock_mode;
  logic strap_hi = 1'h0;
  qbs_lane_t byte_lane_sel_n = '1;
  qbs_addr_t addr = '0;
  qbs_word_t wr_data = '0, rd_data;
  int err_count = 0, checks_done = 0;
  qbs_burst_t m [qbs_addr_t];
  qbs_word_t eq [$];
  qbs_addr_t ad [4];
  qbs_sram_port DUT (.*);
  qbs_ctl_model CTL (.*);
  initial forever #50 core_clk = ~core_clk;
  function automatic qbs_word_t mrg(qbs_word_t o, qbs_word_t d, qbs_lane_t l);
    for (int i = 0; i < $bits(l); i++) if (!l[i]) o[i*9 +: 9] = d[i*9 +: 9];
    return o;
  endfunction : mrg
  task automatic chk(string nm, qbs_word_t e, qbs_word_t s);
    checks_done++;
    if (e !== s) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim();
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  task automatic cyc(bit w, bit r, qbs_addr_t wa, qbs_addr_t ra, qbs_lane_t l0, qbs_lane_t l1);
    qbs_word_t w0 = qbs_word_t'($urandom);
    qbs_word_t w1 = qbs_word_t'($urandom);
    @(posedge main_strobe_n) #20;
    write_port_sel_n = !w;
    read_port_sel_n = !r;
    addr = ra;
    wr_data = w0;
    byte_lane_sel_n = l0;
    @(posedge main_strobe_p) #20;
    write_port_sel_n = 1'h1;
    read_port_sel_n = 1'h1;
    addr = wa;
    wr_data = w1;
    byte_lane_sel_n = l1;
    if (r) eq = {eq, m[ra].lo, m[ra].hi};
    if (w) m[wa] = '{mrg(m[wa].hi, w1, l1), mrg(m[wa].lo, w0, l0)};
  endtask : cyc
  task automatic see();
    if (rd_data_oe !== 1'h0) begin
      if (eq.size() == 0) chk("rd_data_oe", '0, qbs_word_t'(rd_data_oe));
      else chk("rd_data", eq.pop_front(), rd_data);
    end
  endtask : see
  always @(posedge read_timing_p or posedge read_timing_n) begin
    #5;
    if (!srst && !strap_hi) see();
  end
  always @(posedge main_strobe_p or posedge main_strobe_n) begin
    #5;
    if (!srst && strap_hi) see();
  end
  initial begin
    void'($urandom(60));
    for (int md = 0; md < 2; md++) begin
      @(negedge core_clk);
      srst = 1'h1;
      @(negedge core_clk);
      strap_hi = md[0];
      repeat (15) @(negedge core_clk);
      srst = 1'h0;
      repeat (30) @(negedge core_clk);
      chk("single_clock_mode", qbs_word_t'(strap_hi), qbs_word_t'(single_clock_mode));
      for (int i = 0; i < 4; i++) begin
        ad[i] = qbs_addr_t'({$urandom, 2'(i)});
        cyc(1, 0, ad[i], ad[0], '0, '0);
      end
      for (int i = 0; i < 4; i++) cyc(1, 0, ad[i], ad[0], qbs_lane_t'(i), qbs_lane_t'(3 - i));
      cyc(0, 0, ad[1], ad[2], '0, '0);
      cyc(0, 1, ad[0], ad[0], '1, '1);
      cyc(0, 0, ad[0], ad[0], '1, '1);
      for (int i = 0; i < 4; i++) cyc(1, 1, ad[(i + 1) % 4], ad[i], '1, '0);
      repeat (4) cyc(0, 0, ad[0], ad[0], '1, '1);
      chk("pending", '0, qbs_word_t'(eq.size()));
    end
    end_sim();
  end
endmodule : tb
